// ### src/dgdfl_channel.sv
/*
  One gate drive channel: command to gate, desaturation fault, soft shutdown,
  blocking time, fault return and lamps. Inputs synchronous to clk_sys.
*/
`timescale 1ns/100ps
module dgdfl_channel
  import dgdfl_pkg::*;
#(
  parameter logic [CNT_W-1:0] BLOCK_CYCLES = CNT_W'(BLOCK_CYC)
)
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic cmd_lit, // Command link, lit means on
  input wire logic desat_sense, // Desaturation comparator
  input wire logic uv_fault, // Supply undervoltage, either rail
  output logic gate_on_q, // Gate full on
  output logic soft_off_q, // Soft shutdown stage active
  output logic fault_lit_q, // Fault return, lit when healthy
  output logic red_lamp_q, // Fault lamp
  output logic green_lamp_q // Healthy lamp
);
  dgdfl_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic fault_now;

  assign fault_now = (state_q == DGDFL_SOFT) || (state_q == DGDFL_BLOCK) || uv_fault;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q <= DGDFL_IDLE;
      cnt_q <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      case (state_q)
        DGDFL_IDLE:
        begin
          if (uv_fault)
          begin
            state_q <= DGDFL_BLOCK;
            cnt_q <= BLOCK_CYCLES;
          end
          else if (cmd_lit)
            state_q <= DGDFL_ON;
        end
        DGDFL_ON:
        begin
          if (uv_fault)
          begin
            state_q <= DGDFL_BLOCK;
            cnt_q <= BLOCK_CYCLES;
          end
          else if (desat_sense)
          begin
            state_q <= DGDFL_SOFT;
            cnt_q <= CNT_W'(SOFT_OFF_CYC);
          end
          else if (!cmd_lit)
            state_q <= DGDFL_IDLE;
        end
        DGDFL_SOFT:
        begin
          if (cnt_q <= CNT_W'(1))
          begin
            state_q <= DGDFL_BLOCK;
            cnt_q <= BLOCK_CYCLES;
          end
          else
            cnt_q <= cnt_q - CNT_W'(1);
        end
        DGDFL_BLOCK:
        begin
          if (uv_fault)
            cnt_q <= BLOCK_CYCLES;
          else if (cnt_q <= CNT_W'(1))
            state_q <= DGDFL_IDLE;
          else
            cnt_q <= cnt_q - CNT_W'(1);
        end
        default:
          state_q <= DGDFL_IDLE;
      endcase
    end
  end

  // Gate and shutdown stage outputs
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      gate_on_q <= 1'b0;
      soft_off_q <= 1'b0;
    end
    else if (clk_en)
    begin
      gate_on_q <= (state_q == DGDFL_ON) && cmd_lit && !desat_sense && !uv_fault;
      soft_off_q <= (state_q == DGDFL_ON && desat_sense && !uv_fault) ||
                    (state_q == DGDFL_SOFT && cnt_q > CNT_W'(1));
    end
  end

  // Fault return and lamps
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      fault_lit_q <= 1'b1;
      red_lamp_q <= 1'b0;
      green_lamp_q <= 1'b1;
    end
    else if (clk_en)
    begin
      fault_lit_q <= !fault_now;
      green_lamp_q <= !fault_now;
      if (fault_now)
        red_lamp_q <= 1'b1;
    end
  end
endmodule : dgdfl_channel

// ### src/dgdfl_pkg.sv
/*
  Constants and timing counts for the two-channel gate drive fault logic.
  Assumes a 50 MHz system clock; all pins are synchronous to it.
*/
// Functional notes
// - With no drive command on a channel's input link, that channel's gate stays in the negative off state; the code holds gate_on_q while clk_en is low.
// - The fault return link is lit while the channel is healthy and dark while it is in fault.
// - With the gate on and collector voltage near zero, the desaturation input counts as clear and no fault is raised.
// - A desaturation detect during gate on starts soft shutdown and reports a fault over the return link together; the code drops fault_lit_q one clock later.
// - The red fault lamp lights when a fault triggers and stays lit until the driver is restarted.
// - The green healthy lamp is lit whenever no fault is present and dark otherwise.
// - Soft shutdown begins within the response time of 8 us after a short-circuit fault on either channel.
// - Undervoltage on either secondary supply blocks the gate and reports a fault.
// - Once the fault cause is gone, the fault report releases only after one blocking time has elapsed.
package dgdfl_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RESP_TIME_NS = 8000;
  localparam int RESP_CYC = (RESP_TIME_NS / (1_000_000_000 / CLK_HZ) < 1) ? 1 : RESP_TIME_NS / (1_000_000_000 / CLK_HZ);
  localparam int SOFT_OFF_NS = 2000;
  localparam int SOFT_OFF_CYC = SOFT_OFF_NS / (1_000_000_000 / CLK_HZ);
  localparam int BLOCK_TIME_MS = 90;
  localparam int BLOCK_CYC = BLOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 23;
  localparam logic [CNT_W-1:0] CNT_ZERO = 23'h000000;
  typedef enum logic [1:0] {DGDFL_IDLE, DGDFL_ON, DGDFL_SOFT, DGDFL_BLOCK} dgdfl_state_t;
endpackage : dgdfl_pkg

// ### src/dgdfl_top.sv
/*
  Two-channel gate drive fault logic top.
  Assumes command links and comparators already synchronous to clk_sys.
*/
`timescale 1ns/100ps
module dgdfl_top
  import dgdfl_pkg::*;
#(
  parameter logic [CNT_W-1:0] BLOCK_CYCLES = CNT_W'(BLOCK_CYC)
)
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, restarts driver
  input wire logic clk_en, // Freezes state while low
  input wire logic upper_cmd_lit, // Upper command link
  input wire logic lower_cmd_lit, // Lower command link
  input wire logic upper_desat_sense, // Upper desaturation detect
  input wire logic lower_desat_sense, // Lower desaturation detect
  input wire logic pos_uv, // Positive rail undervoltage
  input wire logic neg_uv, // Negative rail undervoltage
  output logic upper_gate_out, // Upper gate on
  output logic lower_gate_out, // Lower gate on
  output logic upper_soft_off, // Upper soft shutdown
  output logic lower_soft_off, // Lower soft shutdown
  output logic upper_fault_lit, // Upper fault return
  output logic lower_fault_lit, // Lower fault return
  output logic upper_red_lamp, // Upper fault lamp
  output logic lower_red_lamp, // Lower fault lamp
  output logic upper_green_lamp, // Upper healthy lamp
  output logic lower_green_lamp // Lower healthy lamp
);
  logic uv_q;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      uv_q <= 1'b0;
    else if (clk_en)
      uv_q <= pos_uv || neg_uv;
  end

  // Independent channels
  dgdfl_channel #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_upper (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .cmd_lit(upper_cmd_lit), .desat_sense(upper_desat_sense), .uv_fault(uv_q),
    .gate_on_q(upper_gate_out), .soft_off_q(upper_soft_off), .fault_lit_q(upper_fault_lit),
    .red_lamp_q(upper_red_lamp), .green_lamp_q(upper_green_lamp)
  );

  dgdfl_channel #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_lower (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .cmd_lit(lower_cmd_lit), .desat_sense(lower_desat_sense), .uv_fault(uv_q),
    .gate_on_q(lower_gate_out), .soft_off_q(lower_soft_off), .fault_lit_q(lower_fault_lit),
    .red_lamp_q(lower_red_lamp), .green_lamp_q(lower_green_lamp)
  );
endmodule : dgdfl_top

// ### verif/dgdfl_ctrl_model.sv
/* Controller model driving both command links. Assumes bench requests. */
`timescale 1ns/100ps
module dgdfl_ctrl_model (
  input wire logic clk_sys, // Clock
  input wire logic [1:0] want_on, // Requested state
  output logic [1:0] cmd_lit // Lit means on
);
  // Lit follows the request at once, so it changes with the bench off the rising edge
  always_comb cmd_lit = want_on;
endmodule : dgdfl_ctrl_model

// ### verif/dgdfl_monitor.sv
/* Checker on the top ports. Checks only when clk_en is high on this and the previous edge. */
`timescale 1ns/100ps
module dgdfl_monitor (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset
  input wire logic clk_en, // Clock enable
  input wire logic upper_cmd_lit, // Cmd
  input wire logic upper_desat_sense, // Desat
  input wire logic lower_desat_sense, // Desat
  input wire logic pos_uv, // Rail
  input wire logic neg_uv, // Rail
  input wire logic upper_gate_out, // Gate
  input wire logic lower_gate_out, // Gate
  input wire logic upper_soft_off, // Soft
  input wire logic lower_soft_off, // Soft
  input wire logic upper_fault_lit, // Return
  input wire logic upper_red_lamp, // Red
  input wire logic upper_green_lamp // Green
);
  default clocking @(posedge clk_sys); endclocking
  // Enable seen high on this and the previous edge
  logic en_q = 1'b0;
  always @(posedge clk_sys) en_q <= clk_en;
  default disable iff (!reset_n || !clk_en || !en_q);
  wire uv = pos_uv | neg_uv;
  AST_IDLE_OFF: assert property (!$past(upper_cmd_lit) |-> !upper_gate_out) else $error("gate on idle");
  AST_HEALTH: assert property (upper_green_lamp == upper_fault_lit) else $error("lamp vs return");
  AST_CLEAR: assert property (upper_gate_out && upper_cmd_lit && !upper_desat_sense && !uv && !$past(uv)
    |=> upper_gate_out) else $error("gate dropped");
  AST_SOFT: assert property (upper_gate_out && upper_desat_sense && !uv && !$past(uv)
    |=> upper_soft_off && !upper_gate_out) else $error("no soft off");
  AST_SOFT_LOW: assert property (lower_gate_out && lower_desat_sense && !uv && !$past(uv)
    |=> lower_soft_off && !lower_gate_out) else $error("no lower soft off");
  AST_REPORT: assert property ($rose(upper_soft_off) |=> !upper_fault_lit && upper_red_lamp) else $error("no report");
  AST_RED: assert property (upper_red_lamp |=> upper_red_lamp) else $error("red dropped");
  AST_UV: assert property (uv |=> ##2 !upper_gate_out && !lower_gate_out && !upper_fault_lit) else $error("uv");
  AST_HOLD: assert property ($fell(upper_soft_off) |-> !upper_fault_lit [*8]) else $error("early release");
  AST_GREEN_OFF: assert property (upper_soft_off |=> !upper_green_lamp) else $error("green lit in fault");
endmodule : dgdfl_monitor

// ### verif/tb_dual_gate_drive_fault_logic.sv
/* Bench for dgdfl_top with the controller model. Assumes short blocking time. */
`timescale 1ns/100ps
module tb_dual_gate_drive_fault_logic;
  import dgdfl_pkg::*;
  localparam int BLK = 20;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] want = 2'h0;
  logic [1:0] desat = 2'h0;
  logic pos_uv = 1'b0;
  logic clk_en = 1'b1;
  wire logic [1:0] cmd, gt, so, fl, rl, gl;
  int errors = 0;
  int checked = 0;
  always #10 clk_sys = ~clk_sys;
  dgdfl_ctrl_model dgdfl_ctrl_model_i (.clk_sys(clk_sys), .want_on(want), .cmd_lit(cmd));
  dgdfl_top #(.BLOCK_CYCLES(CNT_W'(BLK))) dgdfl_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .upper_cmd_lit(cmd[0]), .lower_cmd_lit(cmd[1]), .upper_desat_sense(desat[0]), .lower_desat_sense(desat[1]),
    .pos_uv(pos_uv), .neg_uv(1'b0), .upper_gate_out(gt[0]), .lower_gate_out(gt[1]), .upper_soft_off(so[0]),
    .lower_soft_off(so[1]), .upper_fault_lit(fl[0]), .lower_fault_lit(fl[1]), .upper_red_lamp(rl[0]),
    .lower_red_lamp(rl[1]), .upper_green_lamp(gl[0]), .lower_green_lamp(gl[1]));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic t_on;
    want = 2'h3;
    cyc(4);
    chk({6'h0, so, gt, fl}, 12'h00f);
    $display("on done");
  endtask : t_on
  task automatic t_freeze;
    clk_en = 1'b0;
    want = 2'h0;
    cyc(3);
    chk({8'h0, gt, fl}, 12'h00f);
    clk_en = 1'b1;
    cyc(2);
    chk({8'h0, gt, fl}, 12'h003);
    want = 2'h3;
    cyc(4);
    chk({8'h0, gt, fl}, 12'h00f);
    $display("freeze done");
  endtask : t_freeze
  task automatic t_desat(input int ch);
    logic [1:0] m;
    int n;
    m = 2'(1 << ch);
    desat[ch] = 1'b1;
    cyc(2);
    chk({2'h0, rl, gl, so, gt, fl}, {2'h0, m, ~m, m, ~m, ~m});
    desat[ch] = 1'b0;
    for (n = 0; n < 300 && fl[ch] !== 1'b1; n++)
      cyc(1);
    if (n == 300)
    begin
      errors++;
      give_verdict();
    end
    chk({10'h0, rl[ch], n >= SOFT_OFF_CYC + BLK - 4 && n <= SOFT_OFF_CYC + BLK + 10}, 12'h003);
    $display("desat done");
  endtask : t_desat
  task automatic t_restart;
    reset_n = 1'b0;
    cyc(2);
    chk({6'h0, rl, gl, gt}, 12'h00c);
    reset_n = 1'b1;
    $display("restart done");
  endtask : t_restart
  task automatic t_uv;
    pos_uv = 1'b1;
    cyc(1);
    pos_uv = 1'b0;
    cyc(3);
    chk({6'h0, gt, fl, rl}, 12'h003);
    $display("uv done");
  endtask : t_uv
  initial
  begin
    cyc(3);
    reset_n = 1'b1;
    t_on();
    t_freeze();
    t_desat(0);
    t_restart();
    t_on();
    t_desat(1);
    t_uv();
    give_verdict();
  end
endmodule : tb_dual_gate_drive_fault_logic
bind dgdfl_top dgdfl_monitor dgdfl_monitor_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
  .upper_cmd_lit(upper_cmd_lit),
  .upper_desat_sense(upper_desat_sense), .lower_desat_sense(lower_desat_sense), .pos_uv(pos_uv), .neg_uv(neg_uv),
  .upper_gate_out(upper_gate_out), .lower_gate_out(lower_gate_out), .upper_soft_off(upper_soft_off),
  .lower_soft_off(lower_soft_off), .upper_fault_lit(upper_fault_lit), .upper_red_lamp(upper_red_lamp),
  .upper_green_lamp(upper_green_lamp));
